// [hdl/hvs_pkg.sv]
package hvs_pkg;

    // Clock and timer durations
    localparam int CLK_HZ       = 40_000_000;
    localparam int LS_TIME_MS   = 100;
    localparam int UV_TIME_MS   = 50;
    localparam int AREC_TIME_S  = 1;
    localparam int REM_TIME_MS  = 200;
    localparam int LS_CYCLES    = CLK_HZ / 1000 * LS_TIME_MS;
    localparam int UV_CYCLES    = CLK_HZ / 1000 * UV_TIME_MS;
    localparam int AREC_CYCLES  = CLK_HZ * AREC_TIME_S;
    localparam int REM_CYCLES   = CLK_HZ / 1000 * REM_TIME_MS;
    localparam int TMR_W        = 26;

    // Timer slots
    localparam int T_LS   = 0;
    localparam int T_UV   = 1;
    localparam int T_AREC = 2;
    localparam int T_REM  = 3;
    localparam int N_TMR  = 4;

    // Comparator input positions in the synchronised vector
    localparam int I_HV       = 0;
    localparam int I_ABOVE_HOLD = 1;
    localparam int I_AT_START = 2;
    localparam int I_AT_STOP  = 3;
    localparam int I_BELOW_4V = 4;
    localparam int I_DISCHGD  = 5;
    localparam int I_REM_OFF  = 6;
    localparam int I_REM_ON   = 7;
    localparam int I_LS_LOW   = 8;
    localparam int I_LINE_UV  = 9;
    localparam int I_LINE_OK  = 10;
    localparam int I_OT       = 11;
    localparam int N_IN       = 12;

    // Register map
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  A_CTRL     = 4'h0;
    localparam logic [3:0]  A_STATUS   = 4'h4;
    localparam logic [3:0]  A_INPUTS   = 4'h8;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
    localparam int          CTRL_RUN   = 0;
    localparam int          ST_CONV    = 16;
    localparam int          ST_REMUSED = 17;
    localparam int          ST_FAULT   = 18;
    localparam int          ST_REMPD   = 19;
    localparam int          ST_TMR_LSB = 20;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [9:0] {
        S_IDLE    = 10'h001,
        S_HOLD    = 10'h002,
        S_CHARGE  = 10'h004,
        S_RUN     = 10'h008,
        S_OFF     = 10'h010,
        S_DISCH   = 10'h020,
        S_UV      = 10'h040,
        S_AREC    = 10'h080,
        S_TSD     = 10'h100,
        S_LINEDIS = 10'h200
    } hvs_state_t;

endpackage

// [hdl/hvs_tmr_if.sv]
`timescale 1ns/1ps
interface hvs_tmr_if;
    logic run;
    logic busy;
    logic done;
    modport ctl (output run, input busy, input done);
    modport tmr (input run, output busy, output done);
endinterface

// [hdl/hvs_timer.sv]
`timescale 1ns/1ps
module hvs_timer
#(
    parameter int TW   = 26,
    parameter int TERM = 4
)
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // Control
    hvs_tmr_if.tmr    t
);
    logic [TW-1:0] cnt_r;

    generate
        if (TERM < 1 || TERM >= (2 ** TW))
        begin : g_chk
            $error("hvs_timer: terminal count does not fit");
        end
    endgenerate

    // Counts while run is high, clears at once when it drops, saturates at the end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else if (ce)
        begin
            if (!t.run)
                cnt_r <= '0;
            else if (cnt_r != TW'(TERM))
                cnt_r <= cnt_r + TW'(1);
        end
    end

    assign t.done = t.run && (cnt_r == TW'(TERM));
    assign t.busy = t.run && (cnt_r != TW'(TERM));
endmodule

// [hdl/hvs_sync.sv]
`timescale 1ns/1ps
module hvs_sync
#(
    parameter int W = 12
)
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else if (ce)
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [hdl/hvs_seq.sv]
// Notes on behaviour
// [RL1] Over-temperature during charging or discharging only pauses, then the sequence resumes; the S_OFF discharge and the S_UV/S_AREC hold regulation ignore it.
// [RL2] High voltage present: start-up source charges to hold level, line-monitor bias on.
// [RL3] Hold level until line-OK, then charge to start level and enable the converter.
// [RL4] First start: remote timer and remote pull-down activate with converter enable.
// [RL5] Remote above off threshold: feedback low at once, discharge supply, enter off-mode.
// [RL6] Off-mode: supply unbiased, start-up source off, only line-sense and remote logic alive.
// [RL7] Off-mode remote below on threshold: full discharge, then hold level and line-monitor bias.
// [RL8] No remote timer on off-mode restart; its latch clears only by line-capacitor discharge.
// [RL9] Line-sense low starts a 100 ms timer in every mode, off-mode included.
// [RL10] Line-sense expiry: feedback low, both discharge switches closed until bias is lost.
// [RL11] Over-temperature protection stays active throughout the line-sense discharge and the S_DISCH discharge.
// [RL12] Line recovery before expiry with supply present abandons both timers, operation continues.
// [RL13] Line undervoltage for 50 ms: feedback low, supply discharged to hold level and held.
// [RL14] After undervoltage stop, line-OK causes full discharge, then normal start from hold.
// [RL15] Restart after undervoltage closes the remote pull-down.
// [RL16] Supply at stop level while running: feedback low, 1 s auto-recovery, hold level.
// [RL17] Auto-recovery expiry: full discharge, then start-up source enabled for a new attempt.
// [RL18] Disable output is the inverse of one converter-enable flag.
// [RL19] Supply forced below 4 V also restarts from a fault.
// [RL20] Timers count the one clock, end at the documented durations, clear when withdrawn.
`timescale 1ns/1ps
module hvs_seq
    import hvs_pkg::*;
#(
    parameter int LS_CYC   = hvs_pkg::LS_CYCLES,
    parameter int UV_CYC   = hvs_pkg::UV_CYCLES,
    parameter int AREC_CYC = hvs_pkg::AREC_CYCLES,
    parameter int REM_CYC  = hvs_pkg::REM_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    // AXI4-Lite write
    input  wire logic [hvs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [hvs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Comparator results
    input  wire logic                       high_voltage_input,
    input  wire logic                       vcc_above_hold,
    input  wire logic                       vcc_at_start,
    input  wire logic                       vcc_at_stop,
    input  wire logic                       vcc_below_4v,
    input  wire logic                       vcc_discharged,
    input  wire logic                       remote_above_off,
    input  wire logic                       remote_below_on,
    input  wire logic                       line_sense_low,
    input  wire logic                       line_undervoltage,
    input  wire logic                       line_ok,
    input  wire logic                       over_temperature_stop,
    // Switch controls
    output logic                            startup_src_en,
    output logic                            vcc_discharge_en,
    output logic                            line_cap_discharge_en,
    output logic                            line_monitor_bias_en,
    output logic                            remote_pulldown_en,
    // Open-drain disable toward the feedback node
    output logic                            disable_out,
    output logic                            disable_oe
);
    import hvs_pkg::*;

    hvs_state_t        state_r;
    hvs_state_t        state_nxt;
    logic [N_IN-1:0]   raw;
    logic [N_IN-1:0]   in_s;
    logic [31:0]       ctrl_r;
    logic              conv_en_r;
    logic              rem_used_r;
    logic              fault_rst_r;
    logic              rem_run_r;
    logic              src_nxt;
    logic              vdis_nxt;
    logic              ldis_nxt;
    logic              bias_nxt;
    logic              pause;
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic [N_TMR-1:0]  tmr_busy;
    logic [N_TMR-1:0]  tmr_done;

    assign raw = {over_temperature_stop, line_ok, line_undervoltage, line_sense_low,
                  remote_below_on, remote_above_off, vcc_discharged, vcc_below_4v,
                  vcc_at_stop, vcc_at_start, vcc_above_hold, high_voltage_input};

    hvs_sync #(.W(N_IN)) u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       (raw),
        .q       (in_s)
    );

    function automatic int term_of(input int idx);
        case (idx)
            T_LS:    term_of = LS_CYC;
            T_UV:    term_of = UV_CYC;
            T_AREC:  term_of = AREC_CYC;
            default: term_of = REM_CYC;
        endcase
    endfunction

    function automatic logic in_state(input hvs_state_t s, input hvs_state_t m);
        in_state = (s & m) != 10'h000;
    endfunction

    hvs_tmr_if tmr[N_TMR]();

    // [RL20] Timer bank
    generate
        for (genvar i = 0; i < N_TMR; i++)
        begin : g_tmr
            hvs_timer #(.TW(TMR_W), .TERM(term_of(i))) u_tmr
            (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .t       (tmr[i])
            );
            assign tmr_busy[i] = tmr[i].busy;
            assign tmr_done[i] = tmr[i].done;
        end
    endgenerate

    // [RL9] Line-sense timer in any mode
    assign tmr[T_LS].run   = in_s[I_LS_LOW];
    // [RL12] Undervoltage timer abandoned on recovery
    assign tmr[T_UV].run   = in_s[I_LINE_UV] && (state_r == S_RUN);
    // [RL16] Auto-recovery timer
    assign tmr[T_AREC].run = (state_r == S_AREC);
    assign tmr[T_REM].run  = rem_run_r;

    // [RL1] Pause in S_HOLD, S_CHARGE, S_DISCH and S_LINEDIS
    assign pause = in_s[I_OT] && in_state(state_r, hvs_state_t'(S_HOLD | S_CHARGE | S_DISCH | S_LINEDIS));

    always_comb
    begin
        state_nxt = state_r;
        if (!ctrl_r[CTRL_RUN])
            state_nxt = S_IDLE;
        // [RL10] Line-sense expiry overrides all but a cleared run bit
        else if (tmr_done[T_LS])
            state_nxt = S_LINEDIS;
        else if (!pause)
        begin
            case (state_r)
                // [RL2] High voltage starts the hold charge
                S_IDLE:    if (in_s[I_HV]) state_nxt = S_HOLD;
                // [RL3] Wait for line-OK at hold level
                S_HOLD:    if (in_s[I_LINE_OK] && in_s[I_ABOVE_HOLD]) state_nxt = S_CHARGE;
                S_CHARGE:  if (in_s[I_AT_START]) state_nxt = S_RUN;
                S_RUN:
                begin
                    if (in_s[I_OT])
                        state_nxt = S_TSD;
                    // [RL5] Remote off, masked while the remote timer runs
                    else if (in_s[I_REM_OFF] && !rem_run_r)
                        state_nxt = S_OFF;
                    // [RL16] Supply at stop level
                    else if (in_s[I_AT_STOP])
                        state_nxt = S_AREC;
                    // [RL13] Undervoltage stop
                    else if (tmr_done[T_UV])
                        state_nxt = S_UV;
                end
                // [RL7] Remote on restarts from off-mode
                S_OFF:     if (in_s[I_REM_ON]) state_nxt = S_DISCH;
                S_DISCH:   if (in_s[I_DISCHGD]) state_nxt = S_HOLD;
                // [RL14] Line-OK after undervoltage stop
                S_UV:      if (in_s[I_LINE_OK]) state_nxt = S_DISCH;
                // [RL17] [RL19] Restart, held off while line-sense timer counts
                S_AREC:
                    if ((tmr_done[T_AREC] || in_s[I_BELOW_4V]) && !tmr_busy[T_LS])
                        state_nxt = S_DISCH;
                S_TSD:     if (!in_s[I_OT]) state_nxt = S_DISCH;
                S_LINEDIS: state_nxt = S_LINEDIS;
                default:   state_nxt = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_r <= S_IDLE;
        else if (ce)
            state_r <= state_nxt;
    end

    always_comb
    begin
        src_nxt  = 1'b0;
        vdis_nxt = 1'b0;
        ldis_nxt = 1'b0;
        bias_nxt = 1'b1;
        case (state_nxt)
            S_IDLE:    bias_nxt = 1'b0;
            // [RL1] Switches idle while too hot
            S_HOLD:    src_nxt = !in_s[I_ABOVE_HOLD] && !in_s[I_OT];
            S_CHARGE:  src_nxt = !in_s[I_OT];
            S_RUN:     src_nxt = 1'b0;
            // [RL6] Off-mode leaves supply unbiased
            S_OFF:
            begin
                vdis_nxt = !in_s[I_DISCHGD];
                bias_nxt = 1'b0;
            end
            S_DISCH:   vdis_nxt = !in_s[I_DISCHGD] && !in_s[I_OT];
            // [RL13] [RL16] Regulate at hold level
            S_UV, S_AREC:
            begin
                src_nxt  = !in_s[I_ABOVE_HOLD];
                vdis_nxt = in_s[I_ABOVE_HOLD];
            end
            S_TSD:     src_nxt = 1'b0;
            // [RL10] [RL11] Both discharge switches, cut while too hot
            S_LINEDIS:
            begin
                vdis_nxt = !in_s[I_OT];
                ldis_nxt = !in_s[I_OT];
                bias_nxt = 1'b0;
            end
            default:   bias_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            startup_src_en        <= 1'b0;
            vcc_discharge_en      <= 1'b0;
            line_cap_discharge_en <= 1'b0;
            line_monitor_bias_en  <= 1'b0;
            conv_en_r             <= 1'b0;
        end
        else if (ce)
        begin
            startup_src_en        <= src_nxt;
            vcc_discharge_en      <= vdis_nxt;
            line_cap_discharge_en <= ldis_nxt;
            line_monitor_bias_en  <= bias_nxt;
            // [RL3] Converter enable only in run
            conv_en_r             <= (state_nxt == S_RUN);
        end
    end

    // [RL18] Disable pin follows the inverted enable flag
    assign disable_out = 1'b0;
    assign disable_oe  = !conv_en_r;
    assign remote_pulldown_en = rem_run_r;

    // Remote timer latch and restart kind
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rem_used_r  <= 1'b0;
            fault_rst_r <= 1'b0;
            rem_run_r   <= 1'b0;
        end
        else if (ce)
        begin
            // [RL8] Only line-capacitor discharge clears the latch
            if (line_cap_discharge_en)
                rem_used_r <= 1'b0;
            else if (state_r == S_CHARGE && state_nxt == S_RUN)
                rem_used_r <= 1'b1;
            if ((state_r == S_UV || state_r == S_AREC || state_r == S_TSD) && state_nxt == S_DISCH)
                fault_rst_r <= 1'b1;
            else if (state_nxt == S_RUN)
                fault_rst_r <= 1'b0;
            // [RL4] [RL15] Pull-down and timer on first or fault restart
            if (state_r == S_CHARGE && state_nxt == S_RUN)
                rem_run_r <= !rem_used_r || fault_rst_r;
            else if (tmr_done[T_REM] || state_nxt != S_RUN)
                rem_run_r <= 1'b0;
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = ce && !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_hold_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            aw_addr_r    <= '0;
            w_data_r     <= '0;
            w_strb_r     <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            ctrl_r       <= CTRL_RST;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid)
            begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_r == A_CTRL)
                begin
                    s_axi_bresp <= RESP_OKAY;
                    for (int b = 0; b < 4; b++)
                        if (w_strb_r[b])
                            ctrl_r[8*b +: 8] <= w_data_r[8*b +: 8];
                end
                else if (aw_addr_r == A_STATUS || aw_addr_r == A_INPUTS)
                    s_axi_bresp <= RESP_OKAY;
                else
                    s_axi_bresp <= RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read path
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= '0;
                case (s_axi_araddr)
                    A_CTRL:   s_axi_rdata <= ctrl_r;
                    A_STATUS:
                    begin
                        s_axi_rdata[9:0] <= state_r;
                        s_axi_rdata[ST_CONV] <= conv_en_r;
                        s_axi_rdata[ST_REMUSED] <= rem_used_r;
                        s_axi_rdata[ST_FAULT] <= fault_rst_r;
                        s_axi_rdata[ST_REMPD] <= rem_run_r;
                        s_axi_rdata[ST_TMR_LSB +: N_TMR] <= tmr_busy;
                    end
                    A_INPUTS: s_axi_rdata[N_IN-1:0] <= in_s;
                    default:  s_axi_rresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [verification/hvs_seq_checker.sv]
`timescale 1ns/1ps
module hvs_seq_checker
#(
    parameter int LS_CYC  = 40,
    parameter int UV_CYC  = 20,
    parameter int REM_CYC = 10
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Comparators
    input wire logic high_voltage_input,
    input wire logic vcc_at_start,
    input wire logic vcc_at_stop,
    input wire logic remote_above_off,
    input wire logic line_sense_low,
    input wire logic line_undervoltage,
    input wire logic over_temperature_stop,
    // Switches
    input wire logic vcc_discharge_en,
    input wire logic line_cap_discharge_en,
    input wire logic line_monitor_bias_en,
    input wire logic remote_pulldown_en,
    input wire logic disable_oe
);
    int ls_r;
    int uv_r;
    int pd_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Held-cycle counts, too long for repetition operators
    always_ff @(posedge aclk)
    begin
        ls_r <= (aresetn && line_sense_low && !over_temperature_stop) ? ls_r + 1 : 0;
        uv_r <= (aresetn && line_undervoltage && !disable_oe) ? uv_r + 1 : 0;
        pd_r <= (aresetn && remote_pulldown_en) ? pd_r + 1 : 0;
    end
    sequence s_pull;
        ##[1:4] disable_oe;
    endsequence
    remote_stop_a: assert property (!disable_oe && !remote_pulldown_en && remote_above_off |-> s_pull)
        else $error("remote off ignored");
    stop_level_a: assert property (!disable_oe && vcc_at_stop |-> s_pull)
        else $error("stop level ignored");
    conv_on_a: assert property ($fell(disable_oe) |-> $past(vcc_at_start, 2))
        else $error("enable before start level");
    pulldown_start_a: assert property ($rose(remote_pulldown_en) |-> $fell(disable_oe))
        else $error("pulldown without enable");
    pulldown_len_a: assert property (pd_r <= REM_CYC + 2)
        else $error("pulldown too long");
    bias_start_a: assert property ($rose(line_monitor_bias_en) |-> $past(high_voltage_input, 3))
        else $error("bias without high voltage");
    line_sense_a: assert property (ls_r >= LS_CYC + 6 |-> disable_oe && vcc_discharge_en && line_cap_discharge_en)
        else $error("line sense expiry missed");
    uv_stop_a: assert property (uv_r <= UV_CYC + 6)
        else $error("undervoltage stop missed");
endmodule

bind hvs_seq hvs_seq_checker #(.LS_CYC(LS_CYC), .UV_CYC(UV_CYC), .REM_CYC(REM_CYC)) hvs_seq_checker_i (
    .aclk, .aresetn, .high_voltage_input, .vcc_at_start, .vcc_at_stop, .remote_above_off,
    .line_sense_low, .line_undervoltage, .over_temperature_stop, .vcc_discharge_en,
    .line_cap_discharge_en, .line_monitor_bias_en, .remote_pulldown_en, .disable_oe);

// [verification/hvs_supply_model.sv]
`timescale 1ns/1ps
module hvs_supply_model
#(
    parameter int HOLD  = 50,
    parameter int START = 220,
    parameter int STOP  = 100
)
(
    // Clock
    input wire logic aclk,
    // Switches and slave load
    input wire logic src_en,
    input wire logic dis_en,
    input wire logic oe,
    input wire logic short_load,
    // Supply comparators
    output logic     above_hold,
    output logic     at_start,
    output logic     at_stop,
    output logic     below_4v,
    output logic     discharged
);
    // Supply in tenths of a volt; a shorted slave drains it only while running
    int vcc = 0;
    always_ff @(posedge aclk)
    begin
        if (src_en)
            vcc <= (vcc > 236) ? 240 : vcc + 4;
        else if (dis_en || (short_load && !oe))
            vcc <= (vcc < 4) ? 0 : vcc - 4;
    end
    assign above_hold = vcc >= HOLD;
    assign at_start   = vcc >= START;
    assign at_stop    = vcc <= STOP;
    assign below_4v   = vcc < 40;
    assign discharged = vcc == 0;
endmodule

// [verification/tb_hvs_seq.sv]
`timescale 1ns/1ps
module tb_hvs_seq;
    import hvs_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, shrt = 0;
    logic        awready, wready, bvalid, arready, rvalid, src, vdis, lcd, bias, pd, dout, doe, ce = 0;
    logic [3:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  bresp, rresp, rsp;
    logic [11:0] cmp = 0;
    logic [4:0]  vs;
    int          mismatches = 0, n_checks = 0;

    hvs_seq #(.LS_CYC(40), .UV_CYC(20), .AREC_CYC(80), .REM_CYC(10)) hvs_seq_i (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .high_voltage_input(cmp[I_HV]), .vcc_above_hold(vs[0]), .vcc_at_start(vs[1]), .vcc_at_stop(vs[2]),
        .vcc_below_4v(vs[3]), .vcc_discharged(vs[4]), .remote_above_off(cmp[I_REM_OFF]),
        .remote_below_on(cmp[I_REM_ON]), .line_sense_low(cmp[I_LS_LOW]), .line_undervoltage(cmp[I_LINE_UV]),
        .line_ok(cmp[I_LINE_OK]), .over_temperature_stop(cmp[I_OT]), .startup_src_en(src),
        .vcc_discharge_en(vdis), .line_cap_discharge_en(lcd), .line_monitor_bias_en(bias),
        .remote_pulldown_en(pd), .disable_out(dout), .disable_oe(doe));
    hvs_supply_model hvs_supply_model_i (.aclk(aclk), .src_en(src), .dis_en(vdis), .oe(doe), .short_load(shrt),
        .above_hold(vs[0]), .at_start(vs[1]), .at_stop(vs[2]), .below_4v(vs[3]), .discharged(vs[4]));

    initial
    begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Every wait is bounded; a hang ends the run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 300)
        begin
            mismatches++;
            $display("unexpected at %0t: timeout", $time);
            stop_test();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            tick(n);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask

    task automatic rd(input logic [3:0] a);
        int n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            tick(n);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        d   = rdata;
        rsp = rresp;
    endtask

    task automatic wait_st(input logic [31:0] v, input logic [31:0] m = 32'h3FF);
        int n = 0;
        do
        begin
            rd(A_STATUS);
            tick(n);
        end
        while ((d & m) !== v);
    endtask

    initial
    begin
        repeat (2) @(posedge aclk);
        chk({awready, wready, arready}, 0);
        aresetn <= 1'b1;
        ce      <= 1'b1;
        rd(A_CTRL);
        chk(d, CTRL_RST);
        rd(4'hC);
        chk(rsp, RESP_SLVERR);
        wr(A_CTRL, 32'h0);
        rd(A_CTRL);
        chk(d, 32'h0);
        wr(A_CTRL, 32'h1);
        wr(A_STATUS, 32'hFFFF_FFFF);
        rd(A_STATUS);
        chk(d[9:0], S_IDLE);
        chk(doe, 1);
        cmp[I_HV] <= 1'b1;
        wait_st(S_HOLD);
        chk(bias, 1);
        cmp[I_OT] <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(src, 0);
        cmp[I_OT] <= 1'b0;
        wait_st(S_HOLD);
        cmp[I_LINE_OK] <= 1'b1;
        wait_st(S_RUN);
        chk(pd, 1);
        chk(doe, 0);
        wait_st(0, 32'h8_0000);
        cmp[I_LS_LOW] <= 1'b1;
        repeat (10) @(posedge aclk);
        cmp[I_LS_LOW] <= 1'b0;
        rd(A_STATUS);
        chk(d[9:0], S_RUN);
        cmp[I_REM_OFF] <= 1'b1;
        wait_st(S_OFF);
        chk({src, bias}, 0);
        cmp[I_REM_OFF] <= 1'b0;
        cmp[I_REM_ON]  <= 1'b1;
        wait_st(S_RUN);
        cmp[I_REM_ON] <= 1'b0;
        chk(pd, 0);
        shrt <= 1'b1;
        wait_st(S_AREC);
        shrt <= 1'b0;
        wait_st(S_RUN);
        cmp[I_LINE_OK] <= 1'b0;
        cmp[I_LINE_UV] <= 1'b1;
        wait_st(S_UV);
        cmp[I_LINE_UV] <= 1'b0;
        cmp[I_LINE_OK] <= 1'b1;
        wait_st(S_RUN);
        chk(pd, 1);
        cmp[I_LS_LOW] <= 1'b1;
        wait_st(S_LINEDIS);
        chk({vdis, lcd, doe}, 7);
        cmp[I_OT] <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(lcd, 0);
        cmp[I_OT] <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(lcd, 1);
        stop_test();
    end
endmodule
